// ==== design/bio_cfg.svh ====
`ifndef BIO_CFG_SVH
`define BIO_CFG_SVH

// ****************************************************************
// Register addresses in data space
// ****************************************************************
`define BIO_LINE_A_ADDR      8'hc0
`define BIO_LINE_B_ADDR      8'hc1
`define BIO_LINE_C_ADDR      8'hc2
`define BIO_LINE_D_ADDR      8'hc3
`define BIO_DIR_A_ADDR       8'hc4
`define BIO_DIR_B_ADDR       8'hc5
`define BIO_DIR_C_ADDR       8'hc6
`define BIO_DIR_D_ADDR       8'hc7
`define BIO_OPT_A_ADDR       8'hcc
`define BIO_OPT_B_ADDR       8'hcd
`define BIO_OPT_C_ADDR       8'hce
`define BIO_OPT_D_ADDR       8'hcf

// ****************************************************************
// Reset values and shared pin positions
// ****************************************************************
`define BIO_REG_RESET        8'h00
`define BIO_PWM_BIT          3
`define BIO_OVF_BIT          2
`define BIO_CAP1_BIT         4
`define BIO_CAP2_BIT         5
`define BIO_SER_OUT_BIT      3
`define BIO_UART_TX_BIT      5

`endif

// ==== design/bio_pkg.sv ====
package bio_pkg;

  typedef enum logic [1:0] {
    BIO_PORT_A = 2'b00,
    BIO_PORT_B = 2'b01,
    BIO_PORT_C = 2'b10,
    BIO_PORT_D = 2'b11
  } bio_port_t;

  typedef enum logic [1:0] {
    BIO_REG_LINE = 2'b00,
    BIO_REG_DIR  = 2'b01,
    BIO_REG_OPT  = 2'b10,
    BIO_REG_NONE = 2'b11
  } bio_reg_kind_t;

  // Data-space access from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bio_bus_t;

  // Per-port pad controls
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] irq_en;
    logic [7:0] analog;
  } bio_pad_t;

  // Alternate function signals from the timer, SPI and UART
  typedef struct packed {
    logic pwm_en;
    logic pwm;
    logic ovf_en;
    logic ovf;
    logic ser_out;
    logic uart_tx_active;
    logic uart_tx;
  } bio_alt_t;

endpackage

// ==== design/bio_pin_cell.sv ====
`timescale 1ns/1ps
// Decodes one pin's mode from direction, option and line value.
module bio_pin_cell (
  input  wire logic dir_i,
  input  wire logic opt_i,
  input  wire logic line_i,
  input  wire logic alt_sel_i,
  input  wire logic alt_val_i,
  input  wire logic alt_od_only_i,
  output logic      drive_low_o,
  output logic      oe_o,
  output logic      out_o,
  output logic      pull_up_o,
  output logic      irq_en_o,
  output logic      analog_o
);
  logic value;

  always_comb begin
    // Open-drain outputs may carry the peripheral; push-pull only on
    // pins whose peripheral allows it
    if (alt_sel_i && (!opt_i || !alt_od_only_i)) begin
      value = alt_val_i;
    end else begin
      value = line_i;
    end
    out_o       = value;
    drive_low_o = dir_i && !opt_i && !value;
    oe_o        = dir_i && (opt_i || !value);
    pull_up_o   = !dir_i && !line_i;
    irq_en_o    = !dir_i && opt_i && !line_i;
    analog_o    = !dir_i && opt_i && line_i;
  end

endmodule

// ==== design/bio_port_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Each port has line value, direction, option bytes; bit n is pin n
// - Dir 0, option 0, line 0: input with pull-up, no interrupt
// - Dir 0, option 0, line 1: input, no pull-up, no interrupt
// - Dir 0, option 1, line 0: input with pull-up and interrupt
// - Dir 0, option 1, line 1: analog input to converter multiplexer
// - Dir 1, option 0: open-drain output of the line value
// - Dir 1, option 1: push-pull output of the line value
// - Reading line value of input pins returns live pin level
// - Line value writes always update the latch
// - Reset clears all registers; pins become pulled-up inputs
// - Input without pull-up is high impedance
// - Interrupt trigger type is chosen by separate interrupt logic
// - Timer output enables low leave shared pins as ordinary pins
// - Capture pins are inputs, always readable, always ordinary pins
// - Serial data-in and clock-in pins are inputs, readable by port
// - Serial data out reaches pin only in open-drain mode
// - UART receive pin is an input, readable by the port
// - UART transmit pin drives line value idle, serial data sending
module bio_port_top
  import bio_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic            rst_b_i,
  input  wire bio_pkg::bio_bus_t bus_i,
  input  wire bio_pkg::bio_alt_t alt_i,
  input  wire logic [31:0]     pin_i,
  output logic [7:0]           rdata_o,
  output logic                 rvalid_o,
  output logic [31:0]          pin_out_o,
  output logic [31:0]          pin_oe_o,
  output logic [31:0]          pull_up_o,
  output logic [31:0]          irq_en_o,
  output logic [31:0]          analog_o,
  output logic [7:0]           cap_pins_o,
  output logic [7:0]           ser_pins_o
);
  import bio_pkg::*;
`include "bio_cfg.svh"

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] line_value_register [4];
  logic [7:0] direction_register  [4];
  logic [7:0] option_register     [4];

  logic [31:0] next_out;
  logic [31:0] next_oe;
  logic [31:0] next_pull;
  logic [31:0] next_irq;
  logic [31:0] next_analog;
  logic [7:0]  next_rdata;

  // Address decode shared by reads and writes
  function automatic bio_reg_kind_t reg_kind(input logic [7:0] a);
    if (a >= `BIO_LINE_A_ADDR && a <= `BIO_LINE_D_ADDR) begin
      reg_kind = BIO_REG_LINE;
    end else if (a >= `BIO_DIR_A_ADDR && a <= `BIO_DIR_D_ADDR) begin
      reg_kind = BIO_REG_DIR;
    end else if (a >= `BIO_OPT_A_ADDR && a <= `BIO_OPT_D_ADDR) begin
      reg_kind = BIO_REG_OPT;
    end else begin
      reg_kind = BIO_REG_NONE;
    end
  endfunction

  bio_reg_kind_t wr_kind;
  bio_reg_kind_t rd_kind;
  bio_port_t     port_sel;

  assign wr_kind  = reg_kind(bus_i.addr);
  assign rd_kind  = wr_kind;
  assign port_sel = bio_port_t'(bus_i.addr[1:0]);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < 4; p++) begin
        line_value_register[p] <= `BIO_REG_RESET;
      end
    end else if (bus_i.wr && wr_kind == BIO_REG_LINE) begin
      line_value_register[port_sel] <= bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < 4; p++) begin
        direction_register[p] <= `BIO_REG_RESET;
      end
    end else if (bus_i.wr && wr_kind == BIO_REG_DIR) begin
      direction_register[port_sel] <= bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < 4; p++) begin
        option_register[p] <= `BIO_REG_RESET;
      end
    end else if (bus_i.wr && wr_kind == BIO_REG_OPT) begin
      option_register[port_sel] <= bus_i.wdata;
    end
  end

  // ****************************************************************
  // Alternate function routing
  // ****************************************************************
  // Capture, serial input and UART receive pins stay ordinary pins;
  // the peripherals just tap the pad levels.
  logic [31:0] alt_sel;
  logic [31:0] alt_val;
  logic [31:0] alt_od_only;

  always_comb begin
    alt_sel     = '0;
    alt_val     = '0;
    alt_od_only = '0;
    // Port A timer outputs, only while enabled
    alt_sel[`BIO_PWM_BIT] = alt_i.pwm_en;
    alt_val[`BIO_PWM_BIT] = alt_i.pwm;
    alt_sel[`BIO_OVF_BIT] = alt_i.ovf_en;
    alt_val[`BIO_OVF_BIT] = alt_i.ovf;
    // Port D serial out, open-drain only
    alt_sel[24 + `BIO_SER_OUT_BIT]     = 1'b1;
    alt_val[24 + `BIO_SER_OUT_BIT]     = alt_i.ser_out;
    alt_od_only[24 + `BIO_SER_OUT_BIT] = 1'b1;
    // Port D UART transmit while a frame is active
    alt_sel[24 + `BIO_UART_TX_BIT] = alt_i.uart_tx_active;
    alt_val[24 + `BIO_UART_TX_BIT] = alt_i.uart_tx;
  end

  // ****************************************************************
  // Pin decode
  // ****************************************************************
  logic [31:0] cell_drive_low;

  for (genvar g = 0; g < 32; g++) begin : g_pin
    bio_pin_cell u_cell (
      .dir_i         (direction_register[g/8][g%8]),
      .opt_i         (option_register[g/8][g%8]),
      .line_i        (line_value_register[g/8][g%8]),
      .alt_sel_i     (alt_sel[g]),
      .alt_val_i     (alt_val[g]),
      .alt_od_only_i (alt_od_only[g]),
      .drive_low_o   (cell_drive_low[g]),
      .oe_o          (next_oe[g]),
      .out_o         (next_out[g]),
      .pull_up_o     (next_pull[g]),
      .irq_en_o      (next_irq[g]),
      .analog_o      (next_analog[g])
    );
  end

  // Pad controls registered: new configuration shows one cycle later
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_out_o <= '0;
      pin_oe_o  <= '0;
      pull_up_o <= '1;
      irq_en_o  <= '0;
      analog_o  <= '0;
    end else begin
      pin_out_o <= next_out;
      pin_oe_o  <= next_oe;
      pull_up_o <= next_pull;
      irq_en_o  <= next_irq;
      analog_o  <= next_analog;
    end
  end

  // Peripheral taps of pad levels, readable at any time
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_pins_o <= '0;
      ser_pins_o <= '0;
    end else begin
      cap_pins_o <= pin_i[7:0];
      ser_pins_o <= pin_i[31:24];
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_comb begin
    next_rdata = 8'h00;
    if (rd_kind == BIO_REG_LINE) begin
      for (int b = 0; b < 8; b++) begin
        // Inputs read the pad, outputs read the latch
        if (direction_register[port_sel][b]) begin
          next_rdata[b] = line_value_register[port_sel][b];
        end else begin
          next_rdata[b] = pin_i[8 * port_sel + b];
        end
      end
    end else if (rd_kind == BIO_REG_DIR) begin
      next_rdata = direction_register[port_sel];
    end else if (rd_kind == BIO_REG_OPT) begin
      next_rdata = option_register[port_sel];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= bus_i.rd ? next_rdata : 8'h00;
      rvalid_o <= bus_i.rd;
    end
  end

endmodule

// ==== tb/bio_pad_model.sv ====
`timescale 1ns/1ps
// Pads and outside world: resolves each wire from all parties
module bio_pad_model (
  input  wire logic        clock_i,
  input  wire logic [31:0] out_i,
  input  wire logic [31:0] oe_i,
  input  wire logic [31:0] pull_up_i,
  input  wire logic [31:0] ext_en_i,
  input  wire logic [31:0] ext_val_i,
  output logic [31:0]      level_o
);
  logic [31:0] junk = 32'h0;
  // Floating pads wander so nothing can lean on a stale level
  always @(posedge clock_i) begin
    junk <= ~junk;
  end
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      level_o[i] = oe_i[i] ? out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                   pull_up_i[i] ? 1'b1 : junk[i];
    end
  end
endmodule

// ==== tb/bio_port_sva.sv ====
`timescale 1ns/1ps
module bio_port_sva
  import bio_pkg::*;
(
  input wire logic             clock_i,
  input wire logic             rst_b_i,
  input wire bio_pkg::bio_bus_t bus_i,
  input wire logic [7:0]       rdata_o,
  input wire logic             rvalid_o,
  input wire logic [31:0]      pin_oe_o,
  input wire logic [31:0]      pull_up_o,
  input wire logic [31:0]      irq_en_o,
  input wire logic [31:0]      analog_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_rd_answer; bus_i.rd |=> rvalid_o; endproperty
  property p_rv_cause; rvalid_o |-> $past(bus_i.rd); endproperty
  property p_rd_idle; !rvalid_o |-> rdata_o == 8'h00; endproperty
  property p_unmapped;
    bus_i.rd && bus_i.addr == 8'hc8 |=> rdata_o == 8'h00;
  endproperty
  property p_irq_pull; (irq_en_o & ~pull_up_o) == 32'h0; endproperty
  property p_analog;
    (analog_o & (pull_up_o | irq_en_o | pin_oe_o)) == 32'h0;
  endproperty
  property p_reset;
    !$past(rst_b_i) |-> pull_up_o == 32'hffffffff && pin_oe_o == 32'h0;
  endproperty
  // Asks for a quiet cycle after the write, though a newer write there reaches the pads only after the check
  property p_cfg_delay;
    bus_i.wr && bus_i.addr == 8'hc4 && bus_i.wdata == 8'h00 ##1
      !(bus_i.wr && bus_i.addr == 8'hc4) |=> pin_oe_o[7:0] == 8'h00;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  a_rv_cause: assert property (p_rv_cause)
    else $error("stray read valid");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_irq_pull: assert property (p_irq_pull)
    else $error("interrupt without pull-up");
  a_analog: assert property (p_analog)
    else $error("analog pin not isolated");
  a_reset: assert property (p_reset)
    else $error("bad pad state after reset");
  a_cfg_delay: assert property (p_cfg_delay)
    else $error("direction write late on pads");
  c_read: cover property (bus_i.rd ##1 rvalid_o);
  c_irq: cover property (irq_en_o != 32'h0);
  c_analog: cover property (analog_o != 32'h0);
endmodule
bind bio_port_top bio_port_sva bio_port_sva_inst (.clock_i, .rst_b_i,
  .bus_i, .rdata_o, .rvalid_o, .pin_oe_o, .pull_up_o, .irq_en_o,
  .analog_o);

// ==== tb/bio_port_top_test.sv ====
`timescale 1ns/1ps
`include "bio_cfg.svh"
module bio_port_top_test;
  import bio_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  bio_bus_t    bus_i = '0;
  bio_alt_t    alt_i = '0;
  logic [31:0] pin_i, pin_out_o, pin_oe_o, pull_up_o, irq_en_o, analog_o;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] ext_val = 32'h0;
  logic [7:0]  rdata_o, cap_pins_o, ser_pins_o;
  logic        rvalid_o;
  int          num_errors = 0;
  int          checks_done = 0;
  always #10 clock_i = ~clock_i;
  bio_port_top bio_port_top_inst (.clock_i, .rst_b_i, .bus_i, .alt_i,
    .pin_i, .rdata_o, .rvalid_o, .pin_out_o, .pin_oe_o, .pull_up_o,
    .irq_en_o, .analog_o, .cap_pins_o, .ser_pins_o);
  bio_pad_model bio_pad_model_inst (.clock_i, .out_i(pin_out_o),
    .oe_i(pin_oe_o), .pull_up_i(pull_up_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pin_i));
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // Two cycles per write: pads have settled when this returns
  // Whole bytes only, no bit edits on live ports
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus_i.wr = 1'b1;
    bus_i.addr = a;
    bus_i.wdata = d;
    tick(1);
    bus_i.wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
    int n;
    bus_i.rd = 1'b1;
    bus_i.addr = a;
    tick(1);
    bus_i.rd = 1'b0;
    n = 0;
    while (rvalid_o !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) begin
      $display("[ERR] %s expected valid seen none", name);
      num_errors++;
      finish_test();
    end
    cmp(name, {24'h0, exp}, {24'h0, rdata_o});
    tick(1);
  endtask
  initial begin
    tick(10);
    rst_b_i = 1'b1;
    tick(1);
    cmp("pull_up", 32'hffffffff, pull_up_o);
    cmp("oe", 32'h0, pin_oe_o);
    rd(`BIO_DIR_C_ADDR, 8'h00, "dir_c");
    rd(`BIO_OPT_D_ADDR, 8'h00, "opt_d");
    rd(`BIO_LINE_C_ADDR, 8'hff, "line_c");
    // Port B: pin n takes mode n; only pin 3 analog
    ext_en[15:8] = 8'h0a;
    wr(`BIO_LINE_B_ADDR, 8'haa);
    wr(`BIO_OPT_B_ADDR, 8'hcc);
    wr(`BIO_DIR_B_ADDR, 8'hf0);
    cmp("pull_b", 32'h5, {28'h0, pull_up_o[11:8]});
    cmp("irq_b", 32'h4, {28'h0, irq_en_o[11:8]});
    cmp("ana_b", 32'h8, {28'h0, analog_o[11:8]});
    cmp("oe_b", 32'hd0, {24'h0, pin_oe_o[15:8]});
    cmp("out_b", 32'h2, {30'h0, pin_out_o[15:14]});
    rd(`BIO_LINE_B_ADDR, 8'ha5, "line_b");
    ext_val[15:8] = 8'h0a;
    tick(2);
    rd(`BIO_LINE_B_ADDR, 8'haf, "line_b");
    ext_en[15:8] = 8'h00;
    wr(`BIO_DIR_B_ADDR, 8'hff);
    wr(`BIO_OPT_B_ADDR, 8'hff);
    rd(`BIO_LINE_B_ADDR, 8'haa, "line_b");
    // Port A: timer outputs and capture taps
    ext_en[5:4] = 2'b11;
    ext_val[5:4] = 2'b10;
    alt_i.pwm = 1'b1;
    alt_i.ovf = 1'b1;
    wr(`BIO_OPT_A_ADDR, 8'h0c);
    wr(`BIO_DIR_A_ADDR, 8'h0c);
    cmp("out_a", 32'h0, {30'h0, pin_out_o[3:2]});
    cmp("cap", 32'h2, {30'h0, cap_pins_o[5:4]});
    rd(`BIO_LINE_A_ADDR, 8'he3, "line_a");
    alt_i.pwm_en = 1'b1;
    alt_i.ovf_en = 1'b1;
    tick(2);
    cmp("out_a", 32'h3, {30'h0, pin_out_o[3:2]});
    alt_i.pwm_en = 1'b0;
    alt_i.ovf_en = 1'b0;
    wr(`BIO_DIR_A_ADDR, 8'h00);
    cmp("oe_a", 32'h0, {24'h0, pin_oe_o[7:0]});
    // Port D: serial and UART pins
    ext_en[31:24] = 8'h16;
    ext_val[31:24] = 8'h12;
    wr(`BIO_LINE_D_ADDR, 8'h28);
    wr(`BIO_OPT_D_ADDR, 8'h28);
    wr(`BIO_DIR_D_ADDR, 8'h28);
    cmp("ser", 32'h12, {24'h0, ser_pins_o & 8'h16});
    cmp("out_d", 32'h5, {29'h0, pin_out_o[29:27]});
    alt_i.uart_tx_active = 1'b1;
    tick(2);
    cmp("tx", 32'h0, {31'h0, pin_out_o[29]});
    wr(`BIO_OPT_D_ADDR, 8'h20);
    cmp("oe_d3", 32'h1, {31'h0, pin_oe_o[27]});
    alt_i.ser_out = 1'b1;
    tick(2);
    cmp("oe_d3", 32'h0, {31'h0, pin_oe_o[27]});
    wr(8'hc8, 8'hff);
    rd(8'hc8, 8'h00, "unmapped");
    rd(`BIO_DIR_D_ADDR, 8'h28, "dir_d");
    finish_test();
  end
endmodule
